// >>> nfc_pkg.sv
// ============================================================
// Shared constants and types for the notch coefficient bank.
`default_nettype none
package nfc_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [5:0] NFC_IDX_FIRST = 6'h1B;
    localparam logic [5:0] NFC_IDX_SECOND = 6'h1C;
    localparam logic [5:0] NFC_IDX_STATUS = 6'h3F;

    // Field positions inside the 9-bit notch registers.
    localparam int NFC_BIT_COMMIT = 8;
    localparam int NFC_BIT_ENABLE = 7;
    localparam int NFC_HALF_W = 7;
    localparam int NFC_COEFF_W = 14;

    // Reset value of both staged registers.
    localparam logic [8:0] NFC_REG_RESET = 9'h000;

    // AXI4-Lite response codes.
    localparam logic [1:0] NFC_RESP_OKAY = 2'h0;
    localparam logic [1:0] NFC_RESP_SLVERR = 2'h2;

    // Parameter set as the filter datapath sees it.
    typedef struct packed {
        logic notch_enable;
        logic [13:0] coeff_zero;
    } nfc_params_t;

endpackage
`default_nettype wire

// >>> nfc_stage.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// One staged register: a pending copy taken on every write and a
// live copy that only changes on a commit event.
module nfc_stage
    import nfc_pkg::*;
#(
    parameter int W = 8
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic wr_en,
    input wire logic [W-1:0] wr_data,
    input wire logic commit,
    output logic [W-1:0] pend_q,
    output logic [W-1:0] live_q
);

    // Pending copy follows every write, commit flag or not.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pend_q <= NFC_REG_RESET[W-1:0];
        end else if (wr_en) begin
            pend_q <= wr_data;
        end
    end

    // Live copy moves only on a commit; a write in the same cycle
    // goes straight through so the new value applies with the rest.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            live_q <= NFC_REG_RESET[W-1:0];
        end else if (commit) begin
            live_q <= wr_en ? wr_data : pend_q; // (R1) (R3) (R9)
        end
    end

endmodule
`default_nettype wire

// >>> nfc_bank.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Notch filter enable and A0 coefficient bank behind AXI4-Lite.
// Functional notes
// (R1) Commit on first register applies everything together.
// (R2) First register without commit stays pending.
// (R3) Commit on second register applies everything together.
// (R4) Second register without commit stays pending.
// (R5) Commit flags are write-only triggers, read zero.
// (R6) Enable 0 bypasses filter, 1 applies it.
// (R7) First register holds coefficient bits 13:7, reset zero.
// (R8) Second register holds coefficient bits 6:0.
// (R9) External commit input also applies pending values.
// (R10) Datapath keeps old set until a commit.
module nfc_bank
    import nfc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_commit,
    output nfc_params_t params_q,
    output logic filter_bypass_q
);

    // ============================================================
    // Write channel capture.
    logic aw_full_q; // Write address held.
    logic w_full_q; // Write data held.
    logic [ADDR_W-1:0] awaddr_q; // Held write address.
    logic [31:0] wdata_q; // Held write data.
    logic [3:0] wstrb_q; // Held byte enables.
    logic wr_fire; // Both halves held, write happens now.
    logic wr_hit_first; // Write targets the first notch register.
    logic wr_hit_second; // Write targets the second notch register.
    logic [8:0] wr_word; // Nine-bit value seen by the register.
    logic commit_any; // Any commit event this cycle.
    logic [7:0] first_pend, first_live; // Enable plus high half.
    logic [6:0] second_pend, second_live; // Low half.

    assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;
    assign wr_hit_first = wr_fire && wstrb_q[0]
        && (awaddr_q[ADDR_W-1:2] == NFC_IDX_FIRST);
    assign wr_hit_second = wr_fire && wstrb_q[0]
        && (awaddr_q[ADDR_W-1:2] == NFC_IDX_SECOND);
    // Bit 8 sits in byte lane one and only counts when that lane is on.
    assign wr_word = {wdata_q[NFC_BIT_COMMIT] & wstrb_q[1],
                      wdata_q[NFC_BIT_COMMIT-1:0]};
    // The commit flag is never stored, only used as a trigger here.
    assign commit_any = (wr_hit_first && wr_word[NFC_BIT_COMMIT])
        || (wr_hit_second && wr_word[NFC_BIT_COMMIT])
        || ext_commit; // (R1) (R3) (R5) (R9)

    // Address channel: ready while empty and no response is open.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            aw_full_q <= 1'b0;
            s_axi_awready <= 1'b0;
            awaddr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q <= 1'b1;
            s_axi_awready <= 1'b0;
            awaddr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_full_q <= 1'b0;
        end else if (!aw_full_q && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    // Data channel: same scheme as the address channel.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            w_full_q <= 1'b0;
            s_axi_wready <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_q <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_full_q <= 1'b0;
        end else if (!w_full_q && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    // Write response, raised in the cycle after the write is done.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= NFC_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            // Unmapped addresses answer with a slave error.
            if ((awaddr_q[ADDR_W-1:2] == NFC_IDX_FIRST)
                || (awaddr_q[ADDR_W-1:2] == NFC_IDX_SECOND)) begin
                s_axi_bresp <= NFC_RESP_OKAY;
            end else begin
                s_axi_bresp <= NFC_RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ============================================================
    // Staged registers.
    // First register: enable and coefficient bits 13:7.
    nfc_stage #(.W(NFC_HALF_W + 1)) u_first (
        .clock(clock),
        .reset_n(reset_n),
        .wr_en(wr_hit_first), // (R2) (R7)
        .wr_data(wr_word[NFC_BIT_COMMIT-1:0]),
        .commit(commit_any),
        .pend_q(first_pend),
        .live_q(first_live)
    );

    // Second register: coefficient bits 6:0.
    nfc_stage #(.W(NFC_HALF_W)) u_second (
        .clock(clock),
        .reset_n(reset_n),
        .wr_en(wr_hit_second), // (R4) (R8)
        .wr_data(wr_word[NFC_HALF_W-1:0]),
        .commit(commit_any),
        .pend_q(second_pend),
        .live_q(second_live)
    );

    // Live values feed the datapath; they only move on a commit.
    // The first copy holds the enable above the high half, which is
    // the same order as the parameter set, so one driver fills it all.
    assign params_q = {first_live, second_live}; // (R7) (R8) (R10)

    // Bypass flag registered from the same commit event.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            filter_bypass_q <= 1'b1;
        end else if (commit_any) begin
            filter_bypass_q <= wr_hit_first
                ? !wr_word[NFC_BIT_ENABLE]
                : !first_pend[NFC_BIT_ENABLE]; // (R6)
        end
    end

    // ============================================================
    // Read channel: one cycle from address to data.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= NFC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= NFC_RESP_OKAY;
            // Commit flags always read back as zero.
            case (s_axi_araddr[ADDR_W-1:2])
                NFC_IDX_FIRST: begin
                    s_axi_rdata <= {24'h000000, first_pend}; // (R5)
                end
                NFC_IDX_SECOND: begin
                    s_axi_rdata <= {25'h0000000, second_pend}; // (R5)
                end
                NFC_IDX_STATUS: begin
                    s_axi_rdata <= {17'h00000, params_q};
                end
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= NFC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // ============================================================
    // Checks.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    a_first_commit_apply: assert property ( // (R1)
        wr_hit_first && wr_word[NFC_BIT_COMMIT]
        |=> params_q.coeff_zero[13:7] == $past(wdata_q[6:0])
    ) else $error("first register commit did not apply");

    a_first_pending_hold: assert property ( // (R2)
        wr_hit_first && !wr_word[NFC_BIT_COMMIT] && !ext_commit
        |=> $stable(params_q) && first_pend == $past(wdata_q[7:0])
    ) else $error("uncommitted first write changed live set");

    a_second_commit_apply: assert property ( // (R3)
        wr_hit_second && wr_word[NFC_BIT_COMMIT]
        |=> params_q.coeff_zero[6:0] == $past(wdata_q[6:0])
            && params_q.notch_enable == $past(first_pend[7])
    ) else $error("second register commit did not apply all");

    a_second_pending_hold: assert property ( // (R4)
        wr_hit_second && !wr_word[NFC_BIT_COMMIT] && !ext_commit
        |=> $stable(params_q)
    ) else $error("uncommitted second write changed live set");

    // Only the two notch registers carry a flag; the status word has
    // coefficient bits in that position.
    a_flag_reads_zero: assert property ( // (R5)
        s_axi_arvalid && s_axi_arready
        && ((s_axi_araddr[ADDR_W-1:2] == NFC_IDX_FIRST)
            || (s_axi_araddr[ADDR_W-1:2] == NFC_IDX_SECOND))
        |=> s_axi_rvalid && !s_axi_rdata[NFC_BIT_COMMIT]
    ) else $error("commit flag read back as one");

    a_bypass_tracks_enable: assert property ( // (R6)
        commit_any ##1 1'b1 |-> filter_bypass_q == !params_q.notch_enable
    ) else $error("bypass flag disagrees with enable");

    a_ext_commit_apply: assert property ( // (R9)
        ext_commit && !wr_fire
        |=> params_q == {$past(first_pend), $past(second_pend)}
    ) else $error("external commit did not apply pending set");

    a_live_set_stable: assert property ( // (R10)
        !commit_any |=> $stable(params_q)
    ) else $error("live set changed without a commit");

    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid [*1]
    ) else $error("write response dropped before ready");

endmodule
`default_nettype wire

// >>> nfc_bank_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Self-checking bench for the staged notch coefficient bank.
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
    n_errors++; end end
module nfc_bank_tb_top
    import nfc_pkg::*;
;
    logic clock = 1'b0; // Bench clock, 100 ns period.
    logic reset_n = 1'b0; // Asynchronous reset, active low.
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ext_commit = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, filter_bypass_q;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    nfc_params_t params_q;
    logic [1:0] bq[$]; // Expected write responses, oldest first.
    logic [33:0] rq[$]; // Expected read response and data.
    int n_errors = 0;
    int samples_checked = 0;
    integer seed = 32'hB3B2;
    nfc_bank dut (.clock(clock), .reset_n(reset_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .ext_commit(ext_commit),
        .params_q(params_q), .filter_bypass_q(filter_bypass_q));
    // The clock toggles every half period.
    always #50 clock = ~clock;
    // ============================================================
    // Monitor: each answer on the bus is matched to the oldest note.
    always @(posedge clock) begin
        logic [33:0] ex;
        if (s_axi_bvalid && s_axi_bready) begin
            ex = {32'h0, bq.pop_front()};
            `CHK(s_axi_bresp, ex[1:0])
        end
        if (s_axi_rvalid && s_axi_rready) begin
            ex = rq.pop_front();
            `CHK({s_axi_rresp, s_axi_rdata}, ex)
        end
    end
    // ============================================================
    // Bus tasks: requests are held until their own ready is seen.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        bq.push_back(er);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] ex);
        rq.push_back(ex);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
    endtask
    // Compares the live parameter set once the edge has settled.
    task automatic pc(input logic en, input logic [13:0] co);
        @(negedge clock);
        `CHK(params_q, nfc_params_t'({en, co}))
        `CHK(filter_bypass_q, !en)
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ============================================================
    // Main sequence.
    initial begin
        logic [7:0] fa, sa;
        logic [31:0] v;
        logic e, oe;
        logic [6:0] hi, lo, ohi, olo;
        fa = {NFC_IDX_FIRST, 2'b00};
        sa = {NFC_IDX_SECOND, 2'b00};
        {oe, ohi, olo} = 15'h0;
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        pc(1'b0, 14'h0);
        rd(fa, 34'h0);
        rd(sa, 34'h0);
        rd({NFC_IDX_STATUS, 2'b00}, 34'h0);
        rd(8'h00, {NFC_RESP_SLVERR, 32'h0});
        // Each pass stages a random set; passes 0 and 3 commit it via the second register, pass 1 via the first, pass 2 externally.
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            e = v[7];
            hi = v[6:0];
            lo = v[14:8];
            if (i == 1) begin
                wr(sa, {23'h0, 2'b00, lo}, NFC_RESP_OKAY);
                pc(oe, {ohi, olo});
                wr(fa, {24'h1, e, hi}, NFC_RESP_OKAY);
            end else begin
                wr(fa, {24'h0, e, hi}, NFC_RESP_OKAY);
                pc(oe, {ohi, olo});
                wr(sa, {23'h0, i != 2, 1'b0, lo}, NFC_RESP_OKAY);
            end
            if (i == 2) begin
                pc(oe, {ohi, olo});
                @(posedge clock);
                ext_commit <= 1'b1;
                @(posedge clock);
                ext_commit <= 1'b0;
            end
            pc(e, {hi, lo});
            rd(fa, {NFC_RESP_OKAY, 24'h0, e, hi});
            rd({NFC_IDX_STATUS, 2'b00}, {2'b00, 17'h0, e, hi, lo});
            {oe, ohi, olo} = {e, hi, lo};
        end
        // Refused writes leave the live set alone.
        wr(8'h00, 32'h1FF, NFC_RESP_SLVERR);
        wr({NFC_IDX_STATUS, 2'b00}, 32'h1FF, NFC_RESP_SLVERR);
        pc(oe, {ohi, olo});
        repeat (4) @(posedge clock);
        close_out();
    end
    // Cuts a hang short well beyond the expected run length.
    initial begin
        #(100 * 3000);
        n_errors++;
        close_out();
    end
endmodule
`default_nettype wire
